// ==== core/acd_consts.vh ====
// Constants for the channel configuration decoder.
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH
`define ACD_BYTE_TYPE_BIT 7
`define ACD_SWEEP_HI_BIT 6
`define ACD_SWEEP_LO_BIT 5
`define ACD_CHAN_MSB 4
`define ACD_CHAN_LSB 1
`define ACD_SINGLE_BIT 0
`define ACD_SETUP_CLR_BIT 1
`define ACD_SETUP_REF_BIT 5
`define ACD_SWEEP_RESET 2'h0
`define ACD_CHAN_RESET 4'h0
`define ACD_SINGLE_RESET 1'h1
`define ACD_REF_RESET 1'h0
`define ACD_SWEEP_RANGE 2'h0
`define ACD_SWEEP_REPEAT 2'h1
`define ACD_SWEEP_UPPER 2'h2
`define ACD_SWEEP_ONE 2'h3
`define ACD_REPEAT_COUNT 4'h8
`define ACD_INPUT_GND 4'hF
`endif

// ==== core/acd_decode.v ====
// Configuration byte decoder: fields, input mapping and scan stepping.
//
// Behaviour
// - Byte with bit 7 clear is configuration; bit 7 set is setup.
// - Bits 6:5 are the scan field, reset to 00.
// - Bits 4:1 are the channel field, reset to 0000.
// - Four-input variant forces the two upper channel bits to zero.
// - Single-ended codes 0..11 pick that input positive, ground negative.
// - Differential pairs adjacent inputs; between scans an odd code swaps the pair polarity.
// - With reference use, single-ended top input is ignored; scan fields 00 and 10 stop below it.
// - With reference use, ground stands in for the top input on whichever side of its pair it sits.
// - Differential scan steps index by two up to the upper-bits limit.
// - Scan field 00 converts inputs 0 up to the selected one.
// - Scan field 01 converts the selected input eight times.
// - Setup byte with bit 1 clear restores configuration defaults.
`timescale 1ns/1ps
`include "acd_consts.vh"
module acd_decode #(
    parameter FOUR_INPUT = 0
) (
    input wire MCLK,
    input wire RST,
    input wire [7:0] RX_BYTE,
    input wire RX_BYTE_ACKED,
    input wire SCAN_START,
    input wire CONV_DONE,
    output reg [1:0] SWEEP_SELECT,
    output reg [3:0] CHAN_PICK,
    output reg SINGLE_ENDED_SELECT,
    output reg REF_PIN_ROLE,
    output reg [3:0] POS_INPUT,
    output reg [3:0] NEG_INPUT,
    output reg INPUT_IGNORED,
    output reg SCAN_ACTIVE
);
    // Highest input index; in reference use it is the shared reference pin.
    localparam [3:0] TOP_IN = FOUR_INPUT ? 4'h3 : 4'hB;
    // First input of the upper-half scan on each variant.
    localparam [3:0] UPPER_FIRST = FOUR_INPUT ? 4'h2 : 4'h6;
    // The four-input variant has no upper channel bits, so writes to them
    // are dropped at the register and nothing downstream ever sees them.
    localparam [3:0] CHAN_MASK = FOUR_INPUT ? 4'h3 : 4'hF;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    wire [3:0] top_in = TOP_IN;
    reg [1:0] sweep_reg;
    reg [3:0] chan_reg;
    reg single_reg;
    reg ref_reg;
    reg [3:0] idx_reg;
    reg [3:0] cnt_reg;
    reg active_reg;
    reg [3:0] idx_next;
    reg [3:0] last_idx;
    reg [3:0] first_idx;
    reg [3:0] chan_eff;
    reg [3:0] pos_next;
    reg [3:0] neg_next;
    reg ign_next;
    reg [3:0] cur_idx;
    reg scan_done;
    wire is_cfg = RX_BYTE_ACKED && !RX_BYTE[`ACD_BYTE_TYPE_BIT];
    wire is_setup = RX_BYTE_ACKED && RX_BYTE[`ACD_BYTE_TYPE_BIT];
    wire [3:0] wr_chan = RX_BYTE[`ACD_CHAN_MSB:`ACD_CHAN_LSB];

    always @(posedge MCLK) begin
        if (RST) begin
            sweep_reg <= `ACD_SWEEP_RESET;
            chan_reg <= `ACD_CHAN_RESET;
            single_reg <= `ACD_SINGLE_RESET;
            ref_reg <= `ACD_REF_RESET;
        end else if (is_cfg) begin
            sweep_reg <= RX_BYTE[`ACD_SWEEP_HI_BIT:`ACD_SWEEP_LO_BIT];
            chan_reg <= wr_chan & CHAN_MASK;
            single_reg <= RX_BYTE[`ACD_SINGLE_BIT];
        end else if (is_setup) begin
            // The reference role loads on every setup byte, clear or not.
            ref_reg <= RX_BYTE[`ACD_SETUP_REF_BIT];
            if (!RX_BYTE[`ACD_SETUP_CLR_BIT]) begin
                sweep_reg <= `ACD_SWEEP_RESET;
                chan_reg <= `ACD_CHAN_RESET;
                single_reg <= `ACD_SINGLE_RESET;
            end
        end
    end

    // Scan limits; codes above the top input clamp there, which keeps
    // reserved codes harmless rather than meaningful.
    always @* begin
        chan_eff = (chan_reg > top_in) ? top_in : chan_reg;
        last_idx = chan_eff;
        first_idx = 4'h0;
        if (!single_reg) begin
            last_idx = {chan_eff[3:1], 1'b0};
        end else if (ref_reg && last_idx == top_in) begin
            last_idx = top_in - 4'h1;
        end
        if (sweep_reg == `ACD_SWEEP_UPPER) begin
            first_idx = UPPER_FIRST;
            if (last_idx < first_idx) begin
                last_idx = first_idx;
            end
        end
        if (sweep_reg == `ACD_SWEEP_REPEAT || sweep_reg == `ACD_SWEEP_ONE) begin
            first_idx = chan_eff;
            last_idx = chan_eff;
        end
        idx_next = single_reg ? idx_reg + 4'h1 : idx_reg + 4'h2;
    end

    // A scan ends on the conversion that reaches its last index, or on the
    // eighth conversion of a repeat scan.
    always @* begin
        scan_done = 1'b0;
        case (sweep_reg)
            `ACD_SWEEP_REPEAT: begin
                scan_done = (cnt_reg == `ACD_REPEAT_COUNT);
            end
            `ACD_SWEEP_ONE: begin
                scan_done = 1'b1;
            end
            default: begin
                scan_done = (idx_reg >= last_idx);
            end
        endcase
    end

    // Between scans the outputs show the channel field's own pick, so a
    // plain conversion needs no start pulse to select its inputs.
    always @* begin
        cur_idx = active_reg ? idx_reg : chan_eff;
    end

    always @(posedge MCLK) begin
        if (RST) begin
            idx_reg <= 4'h0;
            cnt_reg <= 4'h0;
            active_reg <= ST_IDLE;
        end else if (SCAN_START) begin
            // A start request restarts even a running scan.
            idx_reg <= first_idx;
            cnt_reg <= 4'h1;
            active_reg <= ST_RUN;
        end else if (active_reg == ST_RUN && CONV_DONE) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (scan_done) begin
                active_reg <= ST_IDLE;
            end else if (sweep_reg != `ACD_SWEEP_REPEAT) begin
                idx_reg <= idx_next;
            end
        end
    end

    // Input mapping for the current index; the current differential code
    // keeps its own polarity bit only between scans, so scans step pairs without swapping.
    always @* begin
        pos_next = cur_idx;
        neg_next = `ACD_INPUT_GND;
        ign_next = 1'b0;
        if (single_reg) begin
            if (ref_reg && cur_idx == top_in) begin
                ign_next = 1'b1;
            end
        end else begin
            if (chan_eff[0] && !active_reg) begin
                pos_next = {cur_idx[3:1], 1'b1};
                neg_next = {cur_idx[3:1], 1'b0};
            end else begin
                pos_next = {cur_idx[3:1], 1'b0};
                neg_next = {cur_idx[3:1], 1'b1};
            end
            if (ref_reg && cur_idx[3:1] == top_in[3:1]) begin
                // Reference pin cannot be an input; ground stands in for it.
                if (pos_next == top_in) begin
                    pos_next = `ACD_INPUT_GND;
                end else begin
                    neg_next = `ACD_INPUT_GND;
                end
            end
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            SWEEP_SELECT <= `ACD_SWEEP_RESET;
            CHAN_PICK <= `ACD_CHAN_RESET;
            SINGLE_ENDED_SELECT <= `ACD_SINGLE_RESET;
            REF_PIN_ROLE <= `ACD_REF_RESET;
        end else begin
            SWEEP_SELECT <= sweep_reg;
            CHAN_PICK <= chan_reg;
            SINGLE_ENDED_SELECT <= single_reg;
            REF_PIN_ROLE <= ref_reg;
        end
    end

    // Mapping outputs share the field outputs' single stage of delay, so
    // a field and the inputs it selects always change on the same edge.
    always @(posedge MCLK) begin
        if (RST) begin
            POS_INPUT <= 4'h0;
            NEG_INPUT <= `ACD_INPUT_GND;
            INPUT_IGNORED <= 1'b0;
            SCAN_ACTIVE <= 1'b0;
        end else begin
            POS_INPUT <= pos_next;
            NEG_INPUT <= neg_next;
            INPUT_IGNORED <= ign_next;
            SCAN_ACTIVE <= active_reg;
        end
    end
endmodule

// ==== dv/acd_master.sv ====
// Serial master model that hands received bytes to the decoder.
`timescale 1ns/1ps
module acd_master (
    input wire MCLK,
    output reg [7:0] RX_BYTE,
    output reg RX_BYTE_ACKED
);
    initial begin
        RX_BYTE = 8'h00;
        RX_BYTE_ACKED = 1'b0;
    end
    // A byte with ack low models an aborted transfer.
    task send(input [7:0] b, input ack);
        begin
            @(negedge MCLK);
            RX_BYTE = b;
            RX_BYTE_ACKED = ack;
            @(negedge MCLK);
            // Inverted data so a stale byte never looks valid.
            RX_BYTE = ~b;
            RX_BYTE_ACKED = 1'b0;
            repeat (4) @(negedge MCLK);
        end
    endtask
endmodule

// ==== dv/acd_decode_properties.sv ====
// Port checker for the configuration decoder.
`timescale 1ns/1ps
module acd_props (
    input wire MCLK, input wire RST, input wire [7:0] RX_BYTE,
    input wire RX_BYTE_ACKED, input wire SCAN_START,
    input wire [1:0] SWEEP_SELECT, input wire [3:0] CHAN_PICK,
    input wire SINGLE_ENDED_SELECT, input wire REF_PIN_ROLE,
    input wire [3:0] POS_INPUT, input wire [3:0] NEG_INPUT,
    input wire INPUT_IGNORED, input wire SCAN_ACTIVE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    reg [7:0] cfg_reg;
    reg [6:0] prev_reg;
    reg [6:0] prev2_reg;
    wire [6:0] now = {CHAN_PICK, SINGLE_ENDED_SELECT, REF_PIN_ROLE, SCAN_ACTIVE};
    wire calm = prev_reg == now && prev2_reg == now && !SCAN_ACTIVE;
    wire cfg_in = RX_BYTE_ACKED && !RX_BYTE[7];
    wire clr_in = RX_BYTE_ACKED && RX_BYTE[7] && !RX_BYTE[1];
    always @(posedge MCLK) begin
        prev_reg <= now;
        prev2_reg <= prev_reg;
        if (RST || clr_in) cfg_reg <= 8'h01;
        else if (cfg_in) cfg_reg <= RX_BYTE;
    end
    property p_sweep; cfg_in |=> ##[0:2] SWEEP_SELECT == cfg_reg[6:5]; endproperty
    a_sweep: assert property (p_sweep) else $error("scan field");
    property p_chan; cfg_in |=> ##[0:2] CHAN_PICK == cfg_reg[4:1]; endproperty
    a_chan: assert property (p_chan) else $error("chan field");
    property p_sgl; cfg_in |=> ##[0:2] SINGLE_ENDED_SELECT == cfg_reg[0]; endproperty
    a_sgl: assert property (p_sgl) else $error("mode bit");
    property p_rst; disable iff (1'b0) RST ##1 RST |=> SWEEP_SELECT == 2'h0
        && CHAN_PICK == 4'h0 && SINGLE_ENDED_SELECT && NEG_INPUT == 4'hF; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_clr; clr_in |-> ##[1:3] CHAN_PICK == 4'h0 && SINGLE_ENDED_SELECT;
    endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_se; calm && SINGLE_ENDED_SELECT |-> POS_INPUT == CHAN_PICK &&
        NEG_INPUT == 4'hF && INPUT_IGNORED == (REF_PIN_ROLE && CHAN_PICK == 4'hB);
    endproperty
    a_se: assert property (p_se) else $error("single map");
    property p_dif; calm && !SINGLE_ENDED_SELECT |-> POS_INPUT == (REF_PIN_ROLE
        && CHAN_PICK == 4'hB ? 4'hF : CHAN_PICK) && NEG_INPUT == (REF_PIN_ROLE
        && CHAN_PICK == 4'hA ? 4'hF : CHAN_PICK ^ 4'h1); endproperty
    a_dif: assert property (p_dif) else $error("diff map");
    property p_scan; SCAN_START && SWEEP_SELECT == 2'h0 |-> ##[1:3] SCAN_ACTIVE
        && POS_INPUT == 4'h0; endproperty
    a_scan: assert property (p_scan) else $error("scan start");
endmodule
bind acd_decode acd_props chk (.MCLK, .RST, .RX_BYTE, .RX_BYTE_ACKED,
    .SCAN_START, .SWEEP_SELECT, .CHAN_PICK, .SINGLE_ENDED_SELECT,
    .REF_PIN_ROLE, .POS_INPUT, .NEG_INPUT, .INPUT_IGNORED, .SCAN_ACTIVE);

// ==== dv/acd_decode_tb.sv ====
// Self-checking bench for the configuration decoder.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module acd_decode_tb;
    reg mclk = 0, rst = 1, scan_start = 0, conv_done = 0, s = 1, r = 0;
    reg [1:0] sw = 0;
    reg [3:0] ch = 0, p;
    reg [17:0] e_v;
    reg [17:0] exp_q[$];
    wire [7:0] rx_byte;
    wire rx_acked, single, ref_role, ignored, active;
    wire [1:0] sweep;
    wire [3:0] chan, pos, neg;
    integer fail_count = 0, samples_checked = 0, seed = 4, cycles = 0, i;
    event obs;
    always #2.5 mclk = ~mclk;
    acd_master m (.MCLK(mclk), .RX_BYTE(rx_byte), .RX_BYTE_ACKED(rx_acked));
    acd_decode dut (.MCLK(mclk), .RST(rst), .RX_BYTE(rx_byte),
        .RX_BYTE_ACKED(rx_acked), .SCAN_START(scan_start),
        .CONV_DONE(conv_done), .SWEEP_SELECT(sweep), .CHAN_PICK(chan),
        .SINGLE_ENDED_SELECT(single), .REF_PIN_ROLE(ref_role),
        .POS_INPUT(pos), .NEG_INPUT(neg), .INPUT_IGNORED(ignored),
        .SCAN_ACTIVE(active));
    task conclude;
        begin
            $display("checked %0d failed %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task note(input [3:0] pp, input [3:0] nn, input act);
        begin
            exp_q.push_back({sw, ch, s, r, pp, nn, s && r && ch == 4'hB, act});
            ->obs;
        end
    endtask
    task rest;
        note(s ? ch : (r && ch == 4'hB ? 4'hF : ch),
            s ? 4'hF : (r && ch == 4'hA ? 4'hF : ch ^ 4'h1), 1'b0);
    endtask
    task cfg(input [1:0] a, input [3:0] b, input c, input k);
        begin
            m.send({1'b0, a, b, c}, k);
            if (k) {sw, ch, s} = {a, b, c};
            rest;
        end
    endtask
    task setup(input rr, input keep);
        begin
            m.send({2'b10, rr, 3'b000, keep, 1'b0}, 1'b1);
            r = rr;
            if (!keep) {sw, ch, s} = 7'h01;
            rest;
        end
    endtask
    task pulse(input d);
        begin
            @(negedge mclk);
            {scan_start, conv_done} = {!d, d};
            @(negedge mclk);
            {scan_start, conv_done} = 2'b00;
            repeat (3) @(negedge mclk);
        end
    endtask
    // Single scans step by one, differential scans by two from input 0.
    task scan(input c, input [3:0] b);
        begin
            cfg(2'h0, b, c, 1'b1);
            pulse(1'b0);
            for (p = 0; p <= b; p = p + (c ? 4'h1 : 4'h2)) begin
                note(p, c ? 4'hF : p + 4'h1, 1'b1);
                pulse(1'b1);
            end
            cfg(2'h0, b, c, 1'b1);
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            conclude;
        end
    end
    initial forever begin
        @(obs);
        e_v = exp_q.pop_front();
        `CHK({sweep, chan, single, ref_role, pos, neg, ignored, active}, e_v)
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst = 0;
        rest;
        for (i = 0; i < 8; i++)
            cfg($random(seed), 4'({$random(seed)} % 12), $random(seed), 1'b1);
        cfg(2'h2, 4'h5, 1'b0, 1'b0);
        setup(1'b1, 1'b1);
        cfg(2'h0, 4'hB, 1'b1, 1'b1);
        cfg(2'h0, 4'hB, 1'b0, 1'b1);
        cfg(2'h0, 4'hA, 1'b0, 1'b1);
        setup(1'b0, 1'b0);
        scan(1'b1, 4'h3);
        scan(1'b0, 4'h4);
        cfg(2'h1, 4'h2, 1'b1, 1'b1);
        pulse(1'b0);
        repeat (8) begin
            note(4'h2, 4'hF, 1'b1);
            pulse(1'b1);
        end
        rest;
        conclude;
    end
endmodule
